// ### inc/arc_pkg.sv
/*
 * arc_pkg: register map, field layout, bus answers, timing counts and state
 * types shared by the converter control block and its conversion engine.
 * assumes: a 200 MHz single clock and an AXI4-Lite master with 32-bit data.
 */
package arc_pkg;

    // register byte offsets
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFF_MODE = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_CHAN = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_RESULT = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_PF_MODE = 5'h0c;
    localparam logic [ADDR_W-1:0] OFF_PF_THR = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 5'h14;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 5'h18;

    // field layout
    localparam int REG_W = 8;
    localparam int MODE_EN_BIT = 7;
    localparam int MODE_TSEL_LO = 3;
    localparam int TSEL_W = 3;
    localparam int CHAN_SEL_W = 2;
    localparam int PF_EN_BIT = 7;
    localparam int PF_DIR_BIT = 6;
    localparam int RESULT_W = 10;
    localparam int IRQ_W = 2;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_PF_BIT = 1;

    // reset values
    localparam logic [REG_W-1:0] RST_REG = 8'h00;
    localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;
    localparam logic [RESULT_W-1:0] RST_RESULT = 10'h000;

    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int SETTLE_US = 14;
    localparam int SETTLE_CYCLES = (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_BASE_CYCLES = 24;
    localparam int CNT_W = 16;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_WAIT = 2'h1,
        BUS_RESP = 2'h2
    } arc_bus_state_t;

    typedef enum logic [1:0] {
        CONV_OFF = 2'h0,
        CONV_SETTLE = 2'h1,
        CONV_RUN = 2'h2
    } arc_conv_state_t;

endpackage : arc_pkg

// ### design/arc_conv.sv
/*
 * arc_conv: conversion engine; settles after power-up, then converts
 * continuously, one result per conversion period set by the time select.
 * assumes: the analog front end presents a stable digital sample on sample.
 */
`timescale 1ns/10ps
module arc_conv #(
    parameter int BASE_CYCLES = arc_pkg::CONV_BASE_CYCLES,
    parameter int SETTLE = arc_pkg::SETTLE_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // control
    input wire logic run,
    input wire logic restart,
    input wire logic [arc_pkg::TSEL_W-1:0] time_sel,
    input wire logic [arc_pkg::RESULT_W-1:0] sample,
    // result
    output logic done,
    output logic [arc_pkg::RESULT_W-1:0] result
);

    arc_pkg::arc_conv_state_t state, next_state;
    logic [arc_pkg::CNT_W-1:0] cnt, next_cnt, conv_len;
    logic next_done;
    logic [arc_pkg::RESULT_W-1:0] next_result;

    assign conv_len = arc_pkg::CNT_W'((32'(time_sel) + 32'h1) * 32'(BASE_CYCLES));

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        next_cnt = cnt + 16'h1;
        next_done = 1'h0;
        next_result = result;
        unique case (state)
            arc_pkg::CONV_OFF: begin
                next_cnt = 16'h0;
                if (run) begin
                    next_state = arc_pkg::CONV_SETTLE;
                end
            end
            arc_pkg::CONV_SETTLE: begin
                if (cnt == arc_pkg::CNT_W'(SETTLE - 1)) begin
                    next_state = arc_pkg::CONV_RUN;
                    next_cnt = 16'h0;
                end
            end
            arc_pkg::CONV_RUN: begin
                if (cnt == conv_len - 16'h1) begin
                    next_done = 1'h1;
                    next_result = sample;
                    next_cnt = 16'h0;
                end
            end
            default: begin
                next_state = arc_pkg::CONV_OFF;
            end
        endcase
        // a changed setting abandons the conversion in flight
        if (restart && state == arc_pkg::CONV_RUN) begin
            next_cnt = 16'h0;
            next_done = 1'h0;
            next_result = result;
        end
        if (!run) begin
            next_state = arc_pkg::CONV_OFF;
            next_done = 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= arc_pkg::CONV_OFF;
            cnt <= 16'h0;
            done <= 1'h0;
            result <= arc_pkg::RST_RESULT;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            done <= next_done;
            result <= next_result;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // helper: cycles since the last result or restart
    logic [arc_pkg::CNT_W-1:0] gap;
    logic gap_ok;
    always_ff @(posedge clk) begin
        if (srst || !run || restart) begin
            gap <= 16'h0;
            gap_ok <= 1'h0;
        end else if (done) begin
            gap <= 16'h1;
            gap_ok <= 1'h1;
        end else begin
            gap <= gap + 16'h1;
        end
    end

    property p_conv_period;
        @(posedge clk) disable iff (srst)
        (done && gap_ok && $stable(time_sel)) |-> (gap == conv_len);
    endproperty
    a_conv_period: assert property (p_conv_period) else $error("conversion period wrong");

endmodule : arc_conv

// ### design/arc_ctrl.sv
/*
 * arc_ctrl: AXI4-Lite register front of the A/D converter and its
 * power-fail comparator, with sticky event status, mask and interrupt.
 * assumes: one AXI4-Lite master, standby driven by the power manager,
 * a 10-bit sample from the analog front end for the selected channel.
 */
`timescale 1ns/10ps
module arc_ctrl #(
    parameter int BASE_CYCLES = arc_pkg::CONV_BASE_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // read
    input wire logic arvalid,
    output logic arready,
    input wire logic [31:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // analog side
    input wire logic standby,
    input wire logic [arc_pkg::RESULT_W-1:0] sample,
    output logic [arc_pkg::CHAN_SEL_W-1:0] analog_channel,
    output logic conv_active,
    // interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic is_mapped(input logic [arc_pkg::ADDR_W-1:0] a);
        return a == arc_pkg::OFF_MODE || a == arc_pkg::OFF_CHAN ||
            a == arc_pkg::OFF_RESULT || a == arc_pkg::OFF_PF_MODE ||
            a == arc_pkg::OFF_PF_THR || a == arc_pkg::OFF_IRQ_STAT ||
            a == arc_pkg::OFF_IRQ_MASK;
    endfunction : is_mapped

    function automatic logic in_window(input logic [31:0] a);
        return a[31:arc_pkg::ADDR_W] == '0;
    endfunction : in_window

    function automatic logic wr_needs_wait(input logic [arc_pkg::ADDR_W-1:0] a);
        return a == arc_pkg::OFF_MODE || a == arc_pkg::OFF_CHAN ||
            a == arc_pkg::OFF_PF_MODE || a == arc_pkg::OFF_PF_THR;
    endfunction : wr_needs_wait

    ////////////////////////////////////////////////////////////////////////
    arc_pkg::arc_bus_state_t wr_state, next_wr_state, rd_state, next_rd_state;
    logic [arc_pkg::ADDR_W-1:0] wr_addr, next_wr_addr, rd_addr, next_rd_addr;
    logic wr_ok, next_wr_ok, rd_ok, next_rd_ok;
    logic [arc_pkg::REG_W-1:0] wr_byte, next_wr_byte;
    logic wr_lane, next_wr_lane;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic [arc_pkg::REG_W-1:0] mode, next_mode, chan, next_chan;
    logic [arc_pkg::REG_W-1:0] pf_mode, next_pf_mode, pf_thr, next_pf_thr;
    logic [arc_pkg::IRQ_W-1:0] status, next_status, mask, next_mask, set_ev, clr_ev;
    logic next_irq, next_conv_active, restart, next_restart, commit;
    logic conv_done, pf_hit;
    logic [arc_pkg::RESULT_W-1:0] result;
    logic [arc_pkg::REG_W-1:0] res_hi;

    assign res_hi = result[arc_pkg::RESULT_W-1 -: arc_pkg::REG_W];

    ////////////////////////////////////////////////////////////////////////
    // write path: address and data taken in either order
    always_comb begin
        next_wr_state = wr_state;
        next_wr_addr = wr_addr;
        next_wr_ok = wr_ok;
        next_wr_byte = wr_byte;
        next_wr_lane = wr_lane;
        next_awready = awready;
        next_wready = wready;
        next_bvalid = bvalid;
        next_bresp = bresp;
        commit = 1'h0;
        if (awvalid && awready) begin
            next_wr_addr = awaddr[arc_pkg::ADDR_W-1:0];
            next_wr_ok = in_window(awaddr) && is_mapped(awaddr[arc_pkg::ADDR_W-1:0]) &&
                awaddr[arc_pkg::ADDR_W-1:0] != arc_pkg::OFF_RESULT;
            next_awready = 1'h0;
        end
        if (wvalid && wready) begin
            next_wr_byte = wdata[arc_pkg::REG_W-1:0];
            next_wr_lane = wstrb[0];
            next_wready = 1'h0;
        end
        unique case (wr_state)
            arc_pkg::BUS_IDLE: begin
                if (!awready && !wready) begin
                    if (wr_ok && wr_needs_wait(wr_addr)) begin
                        next_wr_state = arc_pkg::BUS_WAIT;
                    end else begin
                        commit = 1'h1;
                        next_bvalid = 1'h1;
                        next_bresp = wr_ok ? arc_pkg::RESP_OKAY : arc_pkg::RESP_SLVERR;
                        next_wr_state = arc_pkg::BUS_RESP;
                    end
                end
            end
            arc_pkg::BUS_WAIT: begin
                commit = 1'h1;
                next_bvalid = 1'h1;
                next_bresp = arc_pkg::RESP_OKAY;
                next_wr_state = arc_pkg::BUS_RESP;
            end
            arc_pkg::BUS_RESP: begin
                if (bready) begin
                    next_bvalid = 1'h0;
                    next_awready = 1'h1;
                    next_wready = 1'h1;
                    next_wr_state = arc_pkg::BUS_IDLE;
                end
            end
            default: begin
                next_wr_state = arc_pkg::BUS_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // register file, events and interrupt
    always_comb begin
        next_mode = mode;
        next_chan = chan;
        next_pf_mode = pf_mode;
        next_pf_thr = pf_thr;
        next_mask = mask;
        next_restart = 1'h0;
        clr_ev = '0;
        if (commit && wr_ok && wr_lane) begin
            unique case (wr_addr)
                arc_pkg::OFF_MODE: begin
                    next_mode = wr_byte;
                    next_restart = 1'h1;
                end
                arc_pkg::OFF_CHAN: begin
                    // upper bits stored as written; only the low bits steer the mux
                    next_chan = wr_byte;
                    next_restart = 1'h1;
                end
                arc_pkg::OFF_PF_MODE: next_pf_mode = wr_byte;
                arc_pkg::OFF_PF_THR: next_pf_thr = wr_byte;
                arc_pkg::OFF_IRQ_STAT: clr_ev = wr_byte[arc_pkg::IRQ_W-1:0];
                arc_pkg::OFF_IRQ_MASK: next_mask = wr_byte[arc_pkg::IRQ_W-1:0];
                default: begin
                end
            endcase
        end
        pf_hit = conv_done && pf_mode[arc_pkg::PF_EN_BIT] &&
            (pf_mode[arc_pkg::PF_DIR_BIT] ? (res_hi > pf_thr) : (res_hi <= pf_thr));
        set_ev = '0;
        set_ev[arc_pkg::IRQ_DONE_BIT] = conv_done;
        set_ev[arc_pkg::IRQ_PF_BIT] = pf_hit;
        // a new event outranks a clear in the same cycle
        next_status = (status & ~clr_ev) | set_ev;
        next_irq = |(next_status & next_mask);
        // enable and standby decide power; channel may be set before or after
        next_conv_active = next_mode[arc_pkg::MODE_EN_BIT] && !standby;
    end

    ////////////////////////////////////////////////////////////////////////
    // read path
    always_comb begin
        next_rd_state = rd_state;
        next_rd_addr = rd_addr;
        next_rd_ok = rd_ok;
        next_arready = arready;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        unique case (rd_state)
            arc_pkg::BUS_IDLE: begin
                if (arvalid && arready) begin
                    next_rd_addr = araddr[arc_pkg::ADDR_W-1:0];
                    next_rd_ok = in_window(araddr) && is_mapped(araddr[arc_pkg::ADDR_W-1:0]);
                    next_arready = 1'h0;
                    next_rd_state = (araddr[arc_pkg::ADDR_W-1:0] == arc_pkg::OFF_RESULT) ?
                        arc_pkg::BUS_WAIT : arc_pkg::BUS_RESP;
                    next_rvalid = !next_rd_state[0];
                end
            end
            arc_pkg::BUS_WAIT: begin
                next_rvalid = 1'h1;
                next_rd_state = arc_pkg::BUS_RESP;
            end
            arc_pkg::BUS_RESP: begin
                if (rready) begin
                    next_rvalid = 1'h0;
                    next_arready = 1'h1;
                    next_rd_state = arc_pkg::BUS_IDLE;
                end
            end
            default: begin
                next_rd_state = arc_pkg::BUS_IDLE;
            end
        endcase
        if (next_rvalid && !rvalid) begin
            next_rresp = next_rd_ok ? arc_pkg::RESP_OKAY : arc_pkg::RESP_SLVERR;
            next_rdata = '0;
            if (next_rd_ok) begin
                unique case (next_rd_addr)
                    arc_pkg::OFF_MODE: next_rdata[arc_pkg::REG_W-1:0] = mode;
                    arc_pkg::OFF_CHAN: next_rdata[arc_pkg::REG_W-1:0] = chan;
                    arc_pkg::OFF_RESULT: next_rdata[arc_pkg::RESULT_W-1:0] = result;
                    arc_pkg::OFF_PF_MODE: next_rdata[arc_pkg::REG_W-1:0] = pf_mode;
                    arc_pkg::OFF_PF_THR: next_rdata[arc_pkg::REG_W-1:0] = pf_thr;
                    arc_pkg::OFF_IRQ_STAT: next_rdata[arc_pkg::IRQ_W-1:0] = status;
                    arc_pkg::OFF_IRQ_MASK: next_rdata[arc_pkg::IRQ_W-1:0] = mask;
                    default: begin
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_state <= arc_pkg::BUS_IDLE;
            rd_state <= arc_pkg::BUS_IDLE;
            wr_addr <= '0;
            rd_addr <= '0;
            wr_ok <= 1'h0;
            rd_ok <= 1'h0;
            wr_byte <= arc_pkg::RST_REG;
            wr_lane <= 1'h0;
            awready <= 1'h1;
            wready <= 1'h1;
            arready <= 1'h1;
            bvalid <= 1'h0;
            rvalid <= 1'h0;
            bresp <= arc_pkg::RESP_OKAY;
            rresp <= arc_pkg::RESP_OKAY;
            rdata <= 32'h0;
            mode <= arc_pkg::RST_REG;
            chan <= arc_pkg::RST_REG;
            pf_mode <= arc_pkg::RST_REG;
            pf_thr <= arc_pkg::RST_REG;
            status <= arc_pkg::RST_IRQ;
            mask <= arc_pkg::RST_IRQ;
            irq <= 1'h0;
            conv_active <= 1'h0;
            restart <= 1'h0;
            analog_channel <= '0;
        end else begin
            wr_state <= next_wr_state;
            rd_state <= next_rd_state;
            wr_addr <= next_wr_addr;
            rd_addr <= next_rd_addr;
            wr_ok <= next_wr_ok;
            rd_ok <= next_rd_ok;
            wr_byte <= next_wr_byte;
            wr_lane <= next_wr_lane;
            awready <= next_awready;
            wready <= next_wready;
            arready <= next_arready;
            bvalid <= next_bvalid;
            rvalid <= next_rvalid;
            bresp <= next_bresp;
            rresp <= next_rresp;
            rdata <= next_rdata;
            mode <= next_mode;
            chan <= next_chan;
            pf_mode <= next_pf_mode;
            pf_thr <= next_pf_thr;
            status <= next_status;
            mask <= next_mask;
            irq <= next_irq;
            conv_active <= next_conv_active;
            restart <= next_restart;
            analog_channel <= next_chan[arc_pkg::CHAN_SEL_W-1:0];
        end
    end

    arc_conv #(
        .BASE_CYCLES(BASE_CYCLES),
        .SETTLE(arc_pkg::SETTLE_CYCLES)
    ) u_conv (
        .clk(clk),
        .srst(srst),
        .run(conv_active),
        .restart(restart),
        .time_sel(mode[arc_pkg::MODE_TSEL_LO +: arc_pkg::TSEL_W]),
        .sample(sample),
        .done(conv_done),
        .result(result)
    );

    ////////////////////////////////////////////////////////////////////////
    logic wr_take;
    assign wr_take = wr_state == arc_pkg::BUS_IDLE && !awready && !wready && wr_ok;

    property p_mode_wait;
        @(posedge clk) disable iff (srst)
        (wr_take && wr_addr == arc_pkg::OFF_MODE) |=> !bvalid ##1 bvalid;
    endproperty
    a_mode_wait: assert property (p_mode_wait) else $error("mode write not stretched");

    property p_chan_wait;
        @(posedge clk) disable iff (srst)
        (wr_take && wr_addr == arc_pkg::OFF_CHAN) |=> !bvalid ##1 bvalid;
    endproperty
    a_chan_wait: assert property (p_chan_wait) else $error("chan write not stretched");

    property p_pfm_wait;
        @(posedge clk) disable iff (srst)
        (wr_take && wr_addr == arc_pkg::OFF_PF_MODE) |=> !bvalid ##1 bvalid;
    endproperty
    a_pfm_wait: assert property (p_pfm_wait) else $error("pf mode write not stretched");

    property p_pft_wait;
        @(posedge clk) disable iff (srst)
        (wr_take && wr_addr == arc_pkg::OFF_PF_THR) |=> !bvalid ##1 bvalid;
    endproperty
    a_pft_wait: assert property (p_pft_wait) else $error("pf thr write not stretched");

    property p_result_wait;
        @(posedge clk) disable iff (srst)
        (arvalid && arready && araddr == 32'(arc_pkg::OFF_RESULT)) |=> !rvalid ##1 rvalid;
    endproperty
    a_result_wait: assert property (p_result_wait) else $error("result read too fast");

    property p_standby_stop;
        @(posedge clk) disable iff (srst)
        // conv_active lags standby by one cycle, so a last result may still land
        standby ##1 standby |=> !conv_done && !conv_active;
    endproperty
    a_standby_stop: assert property (p_standby_stop) else $error("ran in standby");

    property p_done_flag;
        @(posedge clk) disable iff (srst)
        conv_done |=> status[arc_pkg::IRQ_DONE_BIT] && (result == $past(sample, 2));
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("completion not flagged");

    property p_irq_level;
        @(posedge clk) disable iff (srst)
        |(status & mask) |-> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

    c_mode_write: cover property (@(posedge clk) disable iff (srst)
        wr_take && wr_addr == arc_pkg::OFF_MODE);
    c_result_read: cover property (@(posedge clk) disable iff (srst)
        rvalid && rready && rd_addr == arc_pkg::OFF_RESULT);
    c_pf_event: cover property (@(posedge clk) disable iff (srst) pf_hit);
    c_irq: cover property (@(posedge clk) disable iff (srst) $rose(irq));

endmodule : arc_ctrl

// ### sim/arc_cpu.sv
/*
 * arc_cpu: AXI4-Lite master model standing for the cpu.
 * assumes: one clock; tasks are called by the bench only.
 */
`timescale 1ns/10ps
module arc_cpu (
    // clock
    input wire logic clk,
    // write
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] awaddr,
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    input wire logic bvalid,
    output logic bready,
    input wire logic [1:0] bresp,
    // read
    output logic arvalid,
    input wire logic arready,
    output logic [31:0] araddr,
    input wire logic rvalid,
    output logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, wdata, araddr} = '0;
        wstrb = 4'h1;
    end
    ////////////////////////////////////////////////////////////////////////
    // lat counts cycles from the later handshake to the answer
    task automatic wr(input logic [31:0] a, d, output logic [1:0] rs, output int lat);
        bit ga, gw, ta, tw, tb;
        {ga, gw} = 2'b00;
        lat = 0;
        @(posedge clk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        forever begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            if (ga && gw) lat++;
            ga |= ta;
            gw |= tw;
            rs = bresp;
            @(posedge clk);
            // released lines show the inverse, not a stale copy
            if (ta) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (tw) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
            if (tb) begin
                bready <= 1'b0;
                break;
            end
        end
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] rs,
                      output int lat);
        bit g, ta, tr;
        g = 1'b0;
        lat = 0;
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        forever begin
            @(negedge clk);
            ta = arvalid && arready;
            tr = rvalid;
            if (g) lat++;
            g |= ta;
            d = rdata;
            rs = rresp;
            @(posedge clk);
            if (ta) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
            if (tr) begin
                rready <= 1'b0;
                break;
            end
        end
    endtask : rd
endmodule : arc_cpu

// ### sim/arc_ctrl_tb_top.sv
/*
 * arc_ctrl_tb_top: self-checking bench of arc_ctrl.
 * assumes: arc_cpu drives the register bus; 200 MHz clock.
 */
`timescale 1ns/10ps
module arc_ctrl_tb_top;
    logic clk = 1'b0, srst = 1'b1, standby = 1'b0;
    logic [9:0] sample = 10'h000;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic conv_active, irq;
    logic [31:0] awaddr, wdata, araddr, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, analog_channel, rs;
    int bad_count = 0, comparisons = 0, cyc = 0, lat;
    always #2.5 clk = ~clk;
    // short conversions keep the run small
    arc_ctrl #(.BASE_CYCLES(2)) dut (.clk(clk), .srst(srst), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .standby(standby),
        .sample(sample), .analog_channel(analog_channel), .conv_active(conv_active), .irq(irq));
    arc_cpu cpu (.clk(clk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic test_done;
        $display("compared %0d, mismatched %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done
    task automatic t_wait;
        logic [31:0] a [5] = '{32'h00, 32'h04, 32'h0c, 32'h10, 32'h18};
        chk("irq", {31'h0, irq}, 32'h0);
        cpu.rd(32'h00, d, rs, lat);
        chk("mode rst", d, 32'h0);
        for (int i = 0; i < 5; i++) begin
            cpu.wr(a[i], 32'h0, rs, lat);
            chk("wr wait", 32'(lat), (i < 4) ? 32'h3 : 32'h2);
        end
        cpu.rd(32'h08, d, rs, lat);
        chk("rd result wait", 32'(lat), 32'h2);
        cpu.rd(32'h04, d, rs, lat);
        chk("rd chan wait", 32'(lat), 32'h1);
        cpu.wr(32'h08, 32'h1, rs, lat);
        chk("wr ro resp", {30'h0, rs}, 32'h2);
        cpu.rd(32'h1c, d, rs, lat);
        chk("unmapped", {rs, d[29:0]}, 32'h80000000);
        $display("t_wait done");
    endtask : t_wait
    ////////////////////////////////////////////////////////////////////////
    task automatic t_conv(input bit rev);
        logic [31:0] m = rev ? 32'h98 : 32'h88;
        logic [9:0] s = rev ? 10'h15a : 10'h2a5;
        int n = 0;
        sample <= s;
        cpu.wr(32'h18, 32'h1, rs, lat);
        // threshold equals the upper result bits of the first sample: boundary hit
        cpu.wr(32'h10, 32'ha9, rs, lat);
        cpu.wr(32'h0c, rev ? 32'hc0 : 32'h80, rs, lat);
        if (rev) cpu.wr(32'h00, m, rs, lat);
        cpu.wr(32'h04, 32'h2, rs, lat);
        if (!rev) cpu.wr(32'h00, m, rs, lat);
        // software waits the settle time before using a result
        while (irq !== 1'b1 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        chk("settle", 32'(n > arc_pkg::SETTLE_CYCLES - 40), 32'h1);
        chk("irq set", {31'h0, irq}, 32'h1);
        cpu.rd(32'h08, d, rs, lat);
        chk("result", d, {22'h0, s});
        cpu.rd(32'h14, d, rs, lat);
        chk("pf status", d, rev ? 32'h1 : 32'h3);
        chk("chan", {30'h0, analog_channel}, 32'h2);
        chk("active", {31'h0, conv_active}, 32'h1);
        cpu.wr(32'h18, 32'h0, rs, lat);
        repeat (2) @(negedge clk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        @(posedge clk);
        standby <= 1'b1;
        repeat (3) @(negedge clk);
        chk("standby", {31'h0, conv_active}, 32'h0);
        @(posedge clk);
        standby <= 1'b0;
        cpu.wr(32'h00, m & 32'h7f, rs, lat);
        cpu.wr(32'h14, 32'h3, rs, lat);
        cpu.rd(32'h14, d, rs, lat);
        chk("w1c", d, 32'h0);
        $display("t_conv done");
    endtask : t_conv
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        t_wait;
        t_conv(1'b0);
        t_conv(1'b1);
        test_done;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            test_done;
        end
    end
endmodule : arc_ctrl_tb_top
